//--- src/tpirq_regs.svh
/*
  Register offsets, field positions, reset values and persistence figures for the threshold persistence
  interrupt block. Assumes inclusion by bare name from the package and the design module.
*/
`ifndef TPIRQ_REGS_SVH
`define TPIRQ_REGS_SVH

`define TPIRQ_ADDR_W 8
`define TPIRQ_LLT_LO 8'h84
`define TPIRQ_LLT_HI 8'h85
`define TPIRQ_LHT_LO 8'h86
`define TPIRQ_LHT_HI 8'h87
`define TPIRQ_PLT_LO 8'h88
`define TPIRQ_PLT_HI 8'h89
`define TPIRQ_PHT_LO 8'h8a
`define TPIRQ_PHT_HI 8'h8b
`define TPIRQ_INTERRUPT_PERSISTENCE 8'h8c
`define TPIRQ_CTRL 8'h90
`define TPIRQ_STATUS 8'h91
`define TPIRQ_MASK 8'h92
`define TPIRQ_LCNT 8'h93
`define TPIRQ_PCNT 8'h94

`define TPIRQ_PROX_PERSISTENCE_FIELD_MSB 7
`define TPIRQ_PROX_PERSISTENCE_FIELD_LSB 4
`define TPIRQ_LPERS_MSB 3
`define TPIRQ_LPERS_LSB 0
`define TPIRQ_CTRL_LIEN 0
`define TPIRQ_CTRL_PIEN 1
`define TPIRQ_ST_LIGHT 0
`define TPIRQ_ST_PROX 1

`define TPIRQ_THR_LOW_RST 16'h0000
`define TPIRQ_THR_HIGH_RST 16'hffff
`define TPIRQ_INTERRUPT_PERSISTENCE_RST 8'h00
`define TPIRQ_CTRL_RST 8'h00
`define TPIRQ_MASK_RST 8'h03

`define TPIRQ_LPERS_LIN_MAX 4'h3
`define TPIRQ_LPERS_MULT 6'h05
`define TPIRQ_LPERS_OFS 6'h03
`define TPIRQ_CNT_MAX 6'h3f

`endif

//--- src/tpirq_pkg.sv
/*
  Types shared by the threshold persistence interrupt block.
  Assumes the register header is on the include path.
*/
package tpirq_pkg;
  `include "tpirq_regs.svh"

  typedef struct packed {
    logic [15:0] low;
    logic [15:0] high;
  } tpirq_window_t;

  typedef struct packed {
    logic valid;
    logic [15:0] value;
  } tpirq_sample_t;

  typedef enum logic [1:0] {
    TPIRQ_IN_WIN = 2'b00,
    TPIRQ_BELOW = 2'b01,
    TPIRQ_ABOVE = 2'b11
  } tpirq_zone_t;
endpackage : tpirq_pkg

//--- src/tpirq_core.sv
/*
  Threshold and persistence interrupt logic for the clear-channel light result and the proximity result,
  with a byte-wide register port. Assumes results arrive as one-cycle valid pulses from conversion logic
  on the same clock, and that the host clears status by reading it.
*/
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
`include "tpirq_regs.svh"

module tpirq_core
  import tpirq_pkg::*;
(
  // Clock and reset.
  input wire logic sys_clk_i,
  input wire logic reset_i,
  // Register port.
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // Conversion results.
  input wire logic clear_valid_i,
  input wire logic [15:0] clear_channel_result_i,
  input wire logic prox_valid_i,
  input wire logic [15:0] proximity_result_i,
  // Interrupt pin.
  output logic irq_o
);

  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic tpirq_zone_t zone_of(input logic [15:0] v, input tpirq_window_t w);
    if (v < w.low)
    begin
      zone_of = TPIRQ_BELOW;
    end
    else if (v > w.high)
    begin
      zone_of = TPIRQ_ABOVE;
    end
    else
    begin
      zone_of = TPIRQ_IN_WIN;
    end
  endfunction : zone_of

  function automatic logic [5:0] light_target(input logic [3:0] f);
    logic [5:0] ext;
    ext = {2'h0, f};
    if (f <= `TPIRQ_LPERS_LIN_MAX)
    begin
      light_target = ext;
    end
    else
    begin
      light_target = 6'((ext - `TPIRQ_LPERS_OFS) * `TPIRQ_LPERS_MULT);
    end
  endfunction : light_target

  // Counters stop at the top, so a long excursion never wraps back under a target.
  function automatic logic [5:0] sat_inc(input logic [5:0] c);
    sat_inc = (c == `TPIRQ_CNT_MAX) ? c : 6'(c + 6'h01);
  endfunction : sat_inc

  // ==========================================================================
  // Registers
  // ==========================================================================
  tpirq_window_t light_win_ff;
  tpirq_window_t prox_win_ff;
  logic [7:0] interrupt_persistence_ff;
  logic [7:0] ctrl_ff;
  logic [1:0] status_ff;
  logic [1:0] mask_ff;
  logic [5:0] light_cnt_ff;
  logic [5:0] prox_cnt_ff;
  tpirq_zone_t prox_zone_ff;
  logic [7:0] rdata_ff;

  logic [3:0] light_persistence_field;
  logic [3:0] prox_persistence_field;
  assign light_persistence_field = interrupt_persistence_ff[`TPIRQ_LPERS_MSB:`TPIRQ_LPERS_LSB];
  assign prox_persistence_field = interrupt_persistence_ff[`TPIRQ_PROX_PERSISTENCE_FIELD_MSB:`TPIRQ_PROX_PERSISTENCE_FIELD_LSB];

  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      light_win_ff <= '{low: `TPIRQ_THR_LOW_RST, high: `TPIRQ_THR_HIGH_RST};
      prox_win_ff <= '{low: `TPIRQ_THR_LOW_RST, high: `TPIRQ_THR_HIGH_RST};
      interrupt_persistence_ff <= `TPIRQ_INTERRUPT_PERSISTENCE_RST;
      ctrl_ff <= `TPIRQ_CTRL_RST;
      mask_ff <= 2'(`TPIRQ_MASK_RST);
    end
    else if (reg_wr_i)
    begin
      case (reg_addr_i)
        `TPIRQ_LLT_LO: light_win_ff.low[7:0] <= reg_wdata_i;
        `TPIRQ_LLT_HI: light_win_ff.low[15:8] <= reg_wdata_i;
        `TPIRQ_LHT_LO: light_win_ff.high[7:0] <= reg_wdata_i;
        `TPIRQ_LHT_HI: light_win_ff.high[15:8] <= reg_wdata_i;
        `TPIRQ_PLT_LO: prox_win_ff.low[7:0] <= reg_wdata_i;
        `TPIRQ_PLT_HI: prox_win_ff.low[15:8] <= reg_wdata_i;
        `TPIRQ_PHT_LO: prox_win_ff.high[7:0] <= reg_wdata_i;
        `TPIRQ_PHT_HI: prox_win_ff.high[15:8] <= reg_wdata_i;
        `TPIRQ_INTERRUPT_PERSISTENCE: interrupt_persistence_ff <= reg_wdata_i;
        `TPIRQ_CTRL: ctrl_ff <= {6'h00, reg_wdata_i[1:0]};
        `TPIRQ_MASK: mask_ff <= reg_wdata_i[1:0];
        default: ;
      endcase
    end
  end

  // ==========================================================================
  // Light persistence
  // ==========================================================================
  tpirq_zone_t light_zone;
  logic light_out;
  logic [5:0] nxt_light_cnt;
  logic light_fire;

  // Only the clear channel feeds this comparison; colour channels never reach the block.
  assign light_zone = zone_of(clear_channel_result_i, light_win_ff);
  assign light_out = (light_zone != TPIRQ_IN_WIN);
  assign nxt_light_cnt = light_out ? sat_inc(light_cnt_ff) : 6'h00;
  assign light_fire = clear_valid_i && ctrl_ff[`TPIRQ_CTRL_LIEN] &&
    ((light_persistence_field == 4'h0) ||
     (light_out && nxt_light_cnt >= light_target(light_persistence_field)));

  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      light_cnt_ff <= 6'h00;
    end
    else if (clear_valid_i)
    begin
      light_cnt_ff <= nxt_light_cnt;
    end
  end

  // ==========================================================================
  // Proximity persistence
  // ==========================================================================
  tpirq_zone_t prox_zone;
  logic prox_out;
  logic prox_cross;
  logic [5:0] nxt_prox_cnt;
  logic prox_fire;

  assign prox_zone = zone_of(proximity_result_i, prox_win_ff);
  assign prox_out = (prox_zone != TPIRQ_IN_WIN);
  // A crossing is a move into a different out-of-window zone than the previous sample.
  assign prox_cross = prox_out && (prox_zone != prox_zone_ff);
  assign nxt_prox_cnt = prox_out ? sat_inc(prox_cnt_ff) : 6'h00;
  // The filter fires on reaching the count, so with a nonzero field a steady out-of-window level gives one indication.
  assign prox_fire = prox_valid_i && ctrl_ff[`TPIRQ_CTRL_PIEN] &&
    ((prox_persistence_field == 4'h0) ||
     (prox_out && nxt_prox_cnt == {2'h0, prox_persistence_field}) ||
     (prox_cross && prox_persistence_field == 4'h1));

  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      prox_cnt_ff <= 6'h00;
      // Starting inside makes the first out-of-window sample after reset count as a crossing.
      prox_zone_ff <= TPIRQ_IN_WIN;
    end
    else if (prox_valid_i)
    begin
      prox_cnt_ff <= nxt_prox_cnt;
      prox_zone_ff <= prox_zone;
    end
  end

  // ==========================================================================
  // Status, mask and interrupt pin
  // ==========================================================================
  logic status_rd;
  logic [1:0] events;
  assign status_rd = reg_rd_i && (reg_addr_i == `TPIRQ_STATUS);
  assign events = {prox_fire, light_fire};

  // A read clears status, but an event in the same cycle stays set.
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      status_ff <= 2'h0;
    end
    else
    begin
      status_ff <= (status_rd ? 2'h0 : status_ff) | events;
    end
  end

  assign irq_o = |(status_ff & mask_ff);

  // ==========================================================================
  // Read data
  // ==========================================================================
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      rdata_ff <= 8'h00;
    end
    else if (reg_rd_i)
    begin
      case (reg_addr_i)
        `TPIRQ_LLT_LO: rdata_ff <= light_win_ff.low[7:0];
        `TPIRQ_LLT_HI: rdata_ff <= light_win_ff.low[15:8];
        `TPIRQ_LHT_LO: rdata_ff <= light_win_ff.high[7:0];
        `TPIRQ_LHT_HI: rdata_ff <= light_win_ff.high[15:8];
        `TPIRQ_PLT_LO: rdata_ff <= prox_win_ff.low[7:0];
        `TPIRQ_PLT_HI: rdata_ff <= prox_win_ff.low[15:8];
        `TPIRQ_PHT_LO: rdata_ff <= prox_win_ff.high[7:0];
        `TPIRQ_PHT_HI: rdata_ff <= prox_win_ff.high[15:8];
        `TPIRQ_INTERRUPT_PERSISTENCE: rdata_ff <= interrupt_persistence_ff;
        `TPIRQ_CTRL: rdata_ff <= ctrl_ff;
        `TPIRQ_STATUS: rdata_ff <= {6'h00, status_ff};
        `TPIRQ_MASK: rdata_ff <= {6'h00, mask_ff};
        `TPIRQ_LCNT: rdata_ff <= {2'h0, light_cnt_ff};
        `TPIRQ_PCNT: rdata_ff <= {2'h0, prox_cnt_ff};
        default: rdata_ff <= 8'h00;
      endcase
    end
    else
    begin
      rdata_ff <= 8'h00;
    end
  end

  // Zero outside the answer cycle, so a stale byte is never taken for a fresh one.
  assign reg_rdata_o = rdata_ff;

  // ==========================================================================
  // Checks
  // ==========================================================================
  chk_light_zero_fire: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    clear_valid_i && ctrl_ff[0] && light_persistence_field == 4'h0 |=> status_ff[0])
    else $error("light event missed with zero persistence");

  chk_prox_zero_fire: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    prox_valid_i && ctrl_ff[1] && prox_persistence_field == 4'h0 |=> status_ff[1])
    else $error("proximity event missed with zero persistence");

  chk_prox_inside_clr: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    prox_valid_i && proximity_result_i >= prox_win_ff.low && proximity_result_i <= prox_win_ff.high
    |=> prox_cnt_ff == 6'h00)
    else $error("proximity counter not cleared inside window");

  chk_light_inside_clr: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    clear_valid_i && clear_channel_result_i >= light_win_ff.low && clear_channel_result_i <= light_win_ff.high
    |=> light_cnt_ff == 6'h00)
    else $error("light counter not cleared inside window");

  chk_cnt_saturate: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    light_cnt_ff == 6'h3f && clear_valid_i && light_out |=> light_cnt_ff == 6'h3f)
    else $error("light counter wrapped");

  chk_prox_count_fire: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    prox_valid_i && ctrl_ff[1] && prox_out && prox_persistence_field != 4'h0 &&
    prox_cnt_ff == 6'(prox_persistence_field - 4'h1) |=> status_ff[1])
    else $error("proximity persistence count reached without event");

  chk_light_long_fire: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    clear_valid_i && ctrl_ff[0] && light_out && light_persistence_field == 4'h4 &&
    light_cnt_ff == 6'h01 |-> !light_fire)
    else $error("light field four fired before five samples");

  chk_irq_hold: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    irq_o && !status_rd && !(reg_wr_i && reg_addr_i == `TPIRQ_MASK) |=> irq_o)
    else $error("interrupt dropped without a status read");

  chk_status_rd_clear: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    status_rd && !light_fire && !prox_fire |=> status_ff == 2'h0)
    else $error("status not cleared by its read");

  chk_light_off_quiet: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    !ctrl_ff[`TPIRQ_CTRL_LIEN] |-> !light_fire)
    else $error("light event raised while disabled");

  chk_prox_off_quiet: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    !ctrl_ff[`TPIRQ_CTRL_PIEN] |-> !prox_fire)
    else $error("proximity event raised while disabled");

  chk_light_long_reach: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    clear_valid_i && ctrl_ff[0] && light_out && light_persistence_field == 4'h4 &&
    light_cnt_ff == 6'h04 |=> status_ff[0])
    else $error("light field four missed its fifth sample");

  chk_light_short_fire: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    clear_valid_i && ctrl_ff[0] && light_out && light_persistence_field == 4'h2 &&
    light_cnt_ff == 6'h01 |=> status_ff[0])
    else $error("light field two missed its second sample");

  chk_light_short_wait: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    clear_valid_i && light_out && light_persistence_field == 4'h2 && light_cnt_ff == 6'h00
    |-> !light_fire)
    else $error("light field two fired on its first sample");

  chk_light_cnt_step: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    clear_valid_i && light_out && light_cnt_ff == 6'h02 |=> light_cnt_ff == 6'h03)
    else $error("light counter did not advance");

  chk_light_cnt_hold: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    !clear_valid_i |=> $stable(light_cnt_ff))
    else $error("light counter moved without a sample");

  chk_prox_cnt_step: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    prox_valid_i && prox_out && prox_cnt_ff == 6'h01 |=> prox_cnt_ff == 6'h02)
    else $error("proximity counter did not advance");

  chk_prox_saturate: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    prox_cnt_ff == 6'h3f && prox_valid_i && prox_out |=> prox_cnt_ff == 6'h3f)
    else $error("proximity counter wrapped");

  chk_prox_cross_fire: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    prox_valid_i && ctrl_ff[1] && prox_persistence_field == 4'h1 && proximity_result_i < prox_win_ff.low &&
    prox_zone_ff != TPIRQ_BELOW |=> status_ff[1])
    else $error("proximity drop below low threshold missed");

  chk_prox_steady_quiet: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    prox_valid_i && prox_persistence_field == 4'h1 && prox_cnt_ff == 6'h01 && prox_out &&
    prox_zone == prox_zone_ff |-> !prox_fire)
    else $error("proximity fired again on a steady level");

endmodule : tpirq_core

//--- testbench/tpirq_host.sv
/*
  Host model: master of the byte-wide register port.
  Assumes one rising-edge clock and that the caller waits for reset release.
*/
`timescale 1ns/1ps
module tpirq_host (
  // Clock.
  input wire logic sys_clk_i,
  // Register port.
  input wire logic [7:0] reg_rdata_i,
  output logic [7:0] reg_addr_o,
  output logic [7:0] reg_wdata_o,
  output logic reg_wr_o,
  output logic reg_rd_o
);
  initial
  begin
    reg_addr_o = 8'h00;
    reg_wdata_o = 8'h00;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    reg_addr_o <= a;
    reg_wdata_o <= d;
    reg_wr_o <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_o <= 1'b0;
  endtask : wr

  // Data stand only in the cycle after the strobe, so they are taken just after that edge.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk_i);
    reg_addr_o <= a;
    reg_rd_o <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd_o <= 1'b0;
    #1 d = reg_rdata_i;
  endtask : rd
endmodule : tpirq_host

//--- testbench/tb.sv
/*
  Self-checking bench for the threshold persistence interrupt block.
  Assumes the host model file and the design sources are compiled first.
*/
`timescale 1ns/1ps
module tb;
  import tpirq_pkg::*;
  logic sys_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic reg_wr, reg_rd, irq_o;
  logic clear_valid_i = 1'b0;
  logic prox_valid_i = 1'b0;
  logic [15:0] clear_channel_result_i = 16'h0000;
  logic [15:0] proximity_result_i = 16'h0000;
  int error_cnt = 0;
  int checked = 0;
  logic [7:0] rst_tab [9] = '{8'h00, 8'h00, 8'hff, 8'hff, 8'h00, 8'h00, 8'hff, 8'hff, 8'h00};
  logic [7:0] win_tab [8] = '{8'h00, 8'h01, 8'h00, 8'h02, 8'h00, 8'h01, 8'h00, 8'h02};

  always #10 sys_clk_i = ~sys_clk_i;

  tpirq_host u_host (.sys_clk_i(sys_clk_i), .reg_rdata_i(reg_rdata), .reg_addr_o(reg_addr),
    .reg_wdata_o(reg_wdata), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd));

  tpirq_core u_dut (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr),
    .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata),
    .clear_valid_i(clear_valid_i), .clear_channel_result_i(clear_channel_result_i),
    .prox_valid_i(prox_valid_i), .proximity_result_i(proximity_result_i), .irq_o(irq_o));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    u_host.rd(a, v);
    chk(v, exp);
  endtask : rdchk

  // One result pulse; status and pin answer at the taking edge and are checked just after it.
  task automatic smp(input bit prox, input logic [15:0] v);
    @(posedge sys_clk_i);
    clear_valid_i <= !prox;
    prox_valid_i <= prox;
    clear_channel_result_i <= v;
    proximity_result_i <= v;
    @(posedge sys_clk_i);
    clear_valid_i <= 1'b0;
    prox_valid_i <= 1'b0;
    #1;
  endtask : smp

  task automatic summarize;
    $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : summarize

  // ==========================================================================
  // Tests
  initial
  begin
    repeat (6) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    for (int i = 0; i < 9; i++) rdchk(8'h84 + 8'(i), rst_tab[i]);
    for (int i = 0; i < 8; i++) u_host.wr(8'h84 + 8'(i), win_tab[i]);
    for (int i = 0; i < 8; i++) rdchk(8'h84 + 8'(i), win_tab[i]);
    rdchk(8'ha0, 8'h00);
    u_host.wr(8'h90, 8'h03);
    u_host.wr(8'h8c, 8'h04);
    repeat (4) smp(0, 16'h0300);
    chk({7'h0, irq_o}, 8'h00);
    smp(0, 16'h0200);
    repeat (4) smp(0, 16'h0050);
    chk({7'h0, irq_o}, 8'h00);
    smp(0, 16'h0050);
    chk({7'h0, irq_o}, 8'h01);
    rdchk(8'h91, 8'h01);
    chk({7'h0, irq_o}, 8'h00);
    rdchk(8'h93, 8'h05);
    u_host.wr(8'h8c, 8'h12);
    smp(0, 16'h0100);
    smp(0, 16'h0250);
    chk({7'h0, irq_o}, 8'h00);
    smp(0, 16'h0250);
    chk({7'h0, irq_o}, 8'h01);
    rdchk(8'h91, 8'h01);
    smp(1, 16'h0250);
    rdchk(8'h91, 8'h02);
    smp(1, 16'h0250);
    rdchk(8'h94, 8'h02);
    rdchk(8'h91, 8'h00);
    smp(1, 16'h0050);
    rdchk(8'h91, 8'h02);
    u_host.wr(8'h8c, 8'h20);
    smp(1, 16'h0150);
    smp(1, 16'h0050);
    chk({7'h0, irq_o}, 8'h00);
    smp(1, 16'h0100);
    smp(1, 16'h0050);
    chk({7'h0, irq_o}, 8'h00);
    smp(1, 16'h0050);
    chk({7'h0, irq_o}, 8'h01);
    rdchk(8'h91, 8'h02);
    u_host.wr(8'h8c, 8'h00);
    smp(0, 16'h0180);
    chk({7'h0, irq_o}, 8'h01);
    rdchk(8'h91, 8'h01);
    smp(1, 16'h0180);
    chk({7'h0, irq_o}, 8'h01);
    rdchk(8'h91, 8'h02);
    u_host.wr(8'h92, 8'h00);
    smp(0, 16'h0180);
    chk({7'h0, irq_o}, 8'h00);
    rdchk(8'h91, 8'h01);
    u_host.wr(8'h90, 8'h00);
    smp(0, 16'h0180);
    rdchk(8'h91, 8'h00);
    summarize();
  end

  initial
  begin
    #100000;
    error_cnt++;
    summarize();
  end
endmodule : tb
